// file: fsps_pkg.sv
`default_nettype none
package fsps_pkg;

    ////////////////////////////////////////////////////////////////////////
    // clocking
    localparam int unsigned CLK_PERIOD_NS = 10;

    ////////////////////////////////////////////////////////////////////////
    // widths
    localparam int unsigned MD_W  = 13;
    localparam int unsigned PER_W = 12;
    localparam int unsigned ACC_W = 26;
    localparam int unsigned PH_W  = 9;
    localparam int unsigned DLY_AW = 8;
    localparam int unsigned DLY_DEPTH = 256;

    ////////////////////////////////////////////////////////////////////////
    // multiply / divide factors
    localparam logic [MD_W-1:0] MD_MAX   = 13'h1000;
    localparam logic [MD_W-1:0] DEF_MULT = 13'h0004;
    localparam logic [MD_W-1:0] DEF_DIV  = 13'h0001;

    ////////////////////////////////////////////////////////////////////////
    // phase shift
    localparam logic signed [PH_W-1:0] PHASE_MAX = 9'sh0FF;
    localparam logic signed [PH_W-1:0] PHASE_MIN = -9'sh0FF;
    localparam logic [3:0]             STEP_SETTLE = 4'h4;

    ////////////////////////////////////////////////////////////////////////
    // lock and loss detection, in clk_i cycles / source edges
    localparam logic [PER_W-1:0] LOSS_TIMEOUT    = 12'hFFF;
    localparam logic [7:0]       LOCK_EDGES_LOW  = 8'h10;
    localparam logic [7:0]       LOCK_EDGES_HIGH = 8'h08;

    ////////////////////////////////////////////////////////////////////////
    // status bits
    localparam int unsigned ST_OVF_BIT  = 0;
    localparam int unsigned ST_LOSS_BIT = 1;

    typedef enum logic [1:0] {
        FSPS_SHIFT_NONE,
        FSPS_SHIFT_FIXED,
        FSPS_SHIFT_VARIABLE
    } fsps_shift_mode_type;

endpackage : fsps_pkg
`default_nettype wire

// file: fsps_step_if.sv
`default_nettype none
interface fsps_step_if;
    logic                    shift_rise;
    logic                    shift_fall;
    logic                    step_en;
    logic                    step_dir;
    logic                    load;
    logic                    variable;
    logic signed [8:0]       cfg_phase;
    logic signed [8:0]       phase;
    logic                    overflow;
    logic                    done;

    modport ctrl (
        output shift_rise, shift_fall, step_en, step_dir,
        output load, variable, cfg_phase,
        input  phase, overflow, done
    );
    modport stepper (
        input  shift_rise, shift_fall, step_en, step_dir,
        input  load, variable, cfg_phase,
        output phase, overflow, done
    );
endinterface : fsps_step_if
`default_nettype wire

// file: fsps_stepper.sv
`default_nettype none
module fsps_stepper (
    // clock and reset
    input  wire logic         clk_i,
    input  wire logic         srst_i,
    // control side
    fsps_step_if.stepper      step
);

    typedef enum logic [1:0] {
        FSPS_ST_IDLE,
        FSPS_ST_SETTLE,
        FSPS_ST_REPORT,
        FSPS_ST_HOLD
    } fsps_step_state_type;

    fsps_step_state_type state_reg;
    logic [3:0]          settle_reg;
    logic signed [8:0]   phase_reg;
    logic                ovf_reg;
    logic                done_reg;
    logic                take;
    logic                at_limit;

    // enable is sampled on the shift clock's falling edge, mid-period, away from its rising edges
    assign take = (state_reg == FSPS_ST_IDLE) && step.variable &&
                  step.shift_fall && step.step_en;
    assign at_limit = step.step_dir ? (phase_reg == fsps_pkg::PHASE_MAX)
                                    : (phase_reg == fsps_pkg::PHASE_MIN);

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_i) begin
        if (srst_i || step.load) begin
            state_reg  <= FSPS_ST_IDLE;
            settle_reg <= 4'h0;
        end else begin
            case (state_reg)
                FSPS_ST_IDLE: begin
                    if (take) begin
                        state_reg  <= FSPS_ST_SETTLE;
                        settle_reg <= fsps_pkg::STEP_SETTLE;
                    end
                end
                FSPS_ST_SETTLE: begin
                    if (settle_reg == 4'h0) begin
                        state_reg <= FSPS_ST_REPORT;
                    end else begin
                        settle_reg <= settle_reg - 4'h1;
                    end
                end
                FSPS_ST_REPORT: begin
                    if (step.shift_rise) begin
                        state_reg <= FSPS_ST_HOLD;
                    end
                end
                FSPS_ST_HOLD: begin
                    if (step.shift_rise) begin
                        state_reg <= FSPS_ST_IDLE;
                    end
                end
                default: begin
                    state_reg <= FSPS_ST_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // requests outside idle never reach the phase register
    always_ff @(posedge clk_i) begin
        if (srst_i || step.load) begin
            phase_reg <= step.cfg_phase;
        end else if (take && !at_limit) begin
            phase_reg <= step.step_dir ? phase_reg + 9'sh001
                                       : phase_reg - 9'sh001;
        end
    end

    // sticky until the next reset
    always_ff @(posedge clk_i) begin
        if (srst_i || step.load) begin
            ovf_reg <= 1'b0;
        end else if (take && at_limit) begin
            ovf_reg <= 1'b1;
        end
    end

    // done stands from one shift-clock rise to the next
    always_ff @(posedge clk_i) begin
        if (srst_i || step.load) begin
            done_reg <= 1'b0;
        end else if (step.shift_rise) begin
            done_reg <= (state_reg == FSPS_ST_REPORT);
        end
    end

    assign step.phase    = phase_reg;
    assign step.overflow = ovf_reg;
    assign step.done     = done_reg;

    ////////////////////////////////////////////////////////////////////////
    property p_phase_range;
        @(posedge clk_i) disable iff (srst_i)
        (phase_reg <= fsps_pkg::PHASE_MAX) &&
        (phase_reg >= fsps_pkg::PHASE_MIN);
    endproperty
    a_phase_range: assert property (p_phase_range)
        else $error("phase factor out of range");

    property p_busy_ignored;
        @(posedge clk_i) disable iff (srst_i || step.load)
        (state_reg != FSPS_ST_IDLE) && step.shift_fall && step.step_en
        |=> $stable(phase_reg);
    endproperty
    a_busy_ignored: assert property (p_busy_ignored)
        else $error("step taken while busy");

    property p_done_drop;
        @(posedge clk_i) disable iff (srst_i || step.load)
        done_reg && step.shift_rise |=> !done_reg;
    endproperty
    a_done_drop: assert property (p_done_drop)
        else $error("done longer than one shift period");

    property p_done_hold;
        @(posedge clk_i) disable iff (srst_i || step.load)
        $rose(done_reg) |-> done_reg until step.shift_rise;
    endproperty
    a_done_hold: assert property (p_done_hold)
        else $error("done dropped early");

    property p_phase_reload;
        @(posedge clk_i)
        step.load |=> phase_reg == $past(step.cfg_phase);
    endproperty
    a_phase_reload: assert property (p_phase_reload)
        else $error("phase not reloaded after reset");

endmodule : fsps_stepper
`default_nettype wire

// file: fsps_top.sv
`default_nettype none
module fsps_top (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        srst_i,
    // source clock and feedback
    input  wire logic        source_clk_in_i,
    input  wire logic        feedback_clk_in_used_i,
    // configuration
    input  wire logic [12:0] synth_multiplier_i,
    input  wire logic [12:0] synth_divisor_i,
    input  wire logic        synth_freq_range_sel_i,
    input  wire logic [1:0]  shift_mode_sel_i,
    input  wire logic [8:0]  cfg_phase_shift_i,
    input  wire logic        hold_config_until_lock_i,
    // phase step handshake
    input  wire logic        shift_clk_i,
    input  wire logic        shift_step_enable_i,
    input  wire logic        shift_direction_i,
    output logic             shift_step_done_o,
    // clock outputs
    output logic             synth_clk_out_o,
    output logic             synth_clk_inv_out_o,
    output logic             deskew_clk_out_o,
    // status
    output logic             locked_o,
    output logic             config_done_o,
    output logic [7:0]       status_o
);

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [12:0] md_sel(input logic [12:0] v,
                                           input logic [12:0] dflt);
        if (v == 13'h0000) begin
            return dflt;
        end else if (v > fsps_pkg::MD_MAX) begin
            return fsps_pkg::MD_MAX;
        end
        return v;
    endfunction : md_sel

    // negative factors wrap to one period minus the magnitude
    function automatic logic [7:0] phase_taps(input logic signed [8:0] n,
                                              input logic [11:0] p);
        logic [8:0]  n_eff;
        logic [20:0] prod;
        n_eff = n[8] ? (9'h100 + 9'(n)) : 9'(n);
        prod  = 21'(n_eff) * 21'(p);
        if (prod[20:8] > 13'h00FF) begin
            return 8'hFF;
        end
        return prod[15:8];
    endfunction : phase_taps

    ////////////////////////////////////////////////////////////////////////
    // synchronisers: 0 source, 1 shift clock, 2 enable, 3 direction
    logic [3:0] sync1_reg;
    logic [3:0] sync2_reg;
    logic [1:0] prev_reg;
    logic       src_rise;

    always_ff @(posedge clk_i) begin
        sync1_reg <= {shift_direction_i, shift_step_enable_i,
                      shift_clk_i, source_clk_in_i};
        sync2_reg <= sync1_reg;
        prev_reg  <= sync2_reg[1:0];
    end

    assign src_rise = sync2_reg[0] && !prev_reg[0];

    fsps_step_if step ();

    assign step.shift_rise = sync2_reg[1] && !prev_reg[1];
    assign step.shift_fall = !sync2_reg[1] && prev_reg[1];
    assign step.step_en    = sync2_reg[2];
    assign step.step_dir   = sync2_reg[3];
    assign step.cfg_phase  = cfg_phase_shift_i;

    ////////////////////////////////////////////////////////////////////////
    // configuration is re-captured from the pins at every reset
    logic                          cfg_load_reg;
    logic [12:0]                   mult_reg;
    logic [12:0]                   div_reg;
    logic                          range_reg;
    fsps_pkg::fsps_shift_mode_type mode_reg;

    always_ff @(posedge clk_i) begin
        cfg_load_reg <= srst_i;
    end

    always_ff @(posedge clk_i) begin
        if (srst_i || cfg_load_reg) begin
            mult_reg  <= md_sel(synth_multiplier_i, fsps_pkg::DEF_MULT);
            div_reg   <= md_sel(synth_divisor_i, fsps_pkg::DEF_DIV);
            range_reg <= synth_freq_range_sel_i;
            case (shift_mode_sel_i)
                2'h1:    mode_reg <= fsps_pkg::FSPS_SHIFT_FIXED;
                2'h2:    mode_reg <= fsps_pkg::FSPS_SHIFT_VARIABLE;
                default: mode_reg <= fsps_pkg::FSPS_SHIFT_NONE;
            endcase
        end
    end

    assign step.load     = srst_i || cfg_load_reg;
    assign step.variable = (mode_reg == fsps_pkg::FSPS_SHIFT_VARIABLE);

    fsps_stepper u_stepper (
        .clk_i  (clk_i),
        .srst_i (srst_i),
        .step   (step.stepper)
    );

    ////////////////////////////////////////////////////////////////////////
    // source period measurement and loss detection
    logic [11:0] cnt_reg;
    logic [11:0] period_reg;
    logic [7:0]  stable_reg;
    logic        lost_reg;
    logic [11:0] diff;

    assign diff = (cnt_reg >= period_reg) ? cnt_reg - period_reg
                                          : period_reg - cnt_reg;

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            cnt_reg    <= 12'h000;
            period_reg <= 12'h000;
            stable_reg <= 8'h00;
            lost_reg   <= 1'b0;
        end else if (src_rise) begin
            cnt_reg    <= 12'h001;
            period_reg <= cnt_reg;
            lost_reg   <= 1'b0;
            if (period_reg != 12'h000 && diff <= 12'h001) begin
                if (stable_reg != 8'hFF) begin
                    stable_reg <= stable_reg + 8'h01;
                end
            end else begin
                stable_reg <= 8'h00;
            end
        end else if (cnt_reg == fsps_pkg::LOSS_TIMEOUT) begin
            lost_reg   <= 1'b1;
            stable_reg <= 8'h00;
        end else begin
            cnt_reg <= cnt_reg + 12'h001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // synthesizer: toggle accumulator; capped at clk_i/2 when 2M >= D*P
    logic [25:0] acc_reg;
    logic        synth_reg;
    logic [12:0] src_cnt_reg;
    logic [25:0] dp;
    logic [25:0] acc_sum;
    logic [25:0] acc_rem;
    logic        align;

    assign dp      = 26'(div_reg * period_reg);
    assign acc_sum = acc_reg + 26'({mult_reg, 1'b0});
    assign acc_rem = acc_sum - dp;
    assign align   = feedback_clk_in_used_i && src_rise &&
                     (src_cnt_reg == 13'h0000);

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            src_cnt_reg <= 13'h0000;
        end else if (src_rise) begin
            src_cnt_reg <= (src_cnt_reg + 13'h0001 >= div_reg) ? 13'h0000
                         : src_cnt_reg + 13'h0001;
        end
    end

    // equal half periods keep the duty at 50/50 within one clk_i
    always_ff @(posedge clk_i) begin
        if (srst_i || period_reg == 12'h000) begin
            acc_reg   <= 26'h0000000;
            synth_reg <= 1'b0;
        end else if (align) begin
            acc_reg   <= 26'h0000000;
            synth_reg <= 1'b1;
        end else if (acc_sum >= dp) begin
            acc_reg   <= (acc_rem >= dp) ? 26'h0000000 : acc_rem;
            synth_reg <= !synth_reg;
        end else begin
            acc_reg <= acc_sum;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // delay line, whole clk_i taps; bit 1 synth, bit 0 source
    logic [1:0]        dly_mem [fsps_pkg::DLY_DEPTH];
    logic [7:0]        wptr_reg;
    logic              wrapped_reg;
    logic signed [8:0] n_eff;
    logic [7:0]        taps_src;
    logic [7:0]        taps_syn;
    logic [1:0]        tap_src;
    logic [1:0]        tap_syn;

    assign n_eff = (mode_reg == fsps_pkg::FSPS_SHIFT_NONE) ? 9'sh000
                 : step.phase;
    assign taps_src = phase_taps(n_eff, period_reg);
    assign taps_syn = feedback_clk_in_used_i ? taps_src : 8'h00;
    assign tap_src  = dly_mem[wptr_reg - 8'h01 - taps_src];
    assign tap_syn  = dly_mem[wptr_reg - 8'h01 - taps_syn];

    always_ff @(posedge clk_i) begin
        dly_mem[wptr_reg] <= {synth_reg, sync2_reg[0]};
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            wptr_reg    <= 8'h00;
            wrapped_reg <= 1'b0;
        end else begin
            wptr_reg <= wptr_reg + 8'h01;
            if (wptr_reg == 8'hFF) begin
                wrapped_reg <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i || !wrapped_reg) begin
            synth_clk_out_o     <= 1'b0;
            synth_clk_inv_out_o <= 1'b1;
            deskew_clk_out_o    <= 1'b0;
        end else begin
            synth_clk_out_o     <= tap_syn[1];
            synth_clk_inv_out_o <= !tap_syn[1];
            deskew_clk_out_o    <= tap_src[0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // lock, configuration done and status
    logic stable_ok;

    assign stable_ok = (stable_reg >= (range_reg ? fsps_pkg::LOCK_EDGES_HIGH
                                                 : fsps_pkg::LOCK_EDGES_LOW));

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            locked_o <= 1'b0;
        end else begin
            locked_o <= stable_ok && !lost_reg && wrapped_reg;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            config_done_o <= !hold_config_until_lock_i;
            status_o      <= 8'h00;
        end else begin
            config_done_o <= !hold_config_until_lock_i || locked_o;
            status_o      <= 8'h00;
            status_o[fsps_pkg::ST_OVF_BIT]  <= step.overflow;
            status_o[fsps_pkg::ST_LOSS_BIT] <= lost_reg &&
                                               feedback_clk_in_used_i;
        end
    end

    assign shift_step_done_o = step.done;

    ////////////////////////////////////////////////////////////////////////
    property p_lock_drop;
        @(posedge clk_i) srst_i |=> !locked_o;
    endproperty
    a_lock_drop: assert property (p_lock_drop)
        else $error("lock kept during reset");

    property p_lock_cause;
        @(posedge clk_i) disable iff (srst_i)
        $rose(locked_o) |-> $past(stable_ok) && !$past(lost_reg);
    endproperty
    a_lock_cause: assert property (p_lock_cause)
        else $error("lock without stable source");

    property p_inverted;
        @(posedge clk_i) disable iff (srst_i)
        synth_clk_inv_out_o == !synth_clk_out_o;
    endproperty
    a_inverted: assert property (p_inverted)
        else $error("inverted output not complement");

    property p_hold_done;
        @(posedge clk_i) disable iff (srst_i)
        hold_config_until_lock_i && $past(hold_config_until_lock_i) &&
        !$past(locked_o) |-> !config_done_o;
    endproperty
    a_hold_done: assert property (p_hold_done)
        else $error("config done before lock");

    property p_loss_fb;
        @(posedge clk_i) disable iff (srst_i)
        status_o[fsps_pkg::ST_LOSS_BIT] |-> $past(feedback_clk_in_used_i);
    endproperty
    a_loss_fb: assert property (p_loss_fb)
        else $error("loss flagged without feedback");

    property p_mult_default;
        @(posedge clk_i)
        cfg_load_reg && (synth_multiplier_i == 13'h0000)
        |=> mult_reg == fsps_pkg::DEF_MULT;
    endproperty
    a_mult_default: assert property (p_mult_default)
        else $error("multiplier default not applied");

endmodule : fsps_top
`default_nettype wire

// file: fsps_step_model.sv
`default_nettype none
module fsps_step_model (
    // bench side
    input  wire logic clk_i,
    input  wire logic req_i,
    input  wire logic dir_i,
    input  wire logic early_i,
    // step handshake
    input  wire logic done_i,
    output logic      shift_clk_o,
    output logic      step_en_o,
    output logic      step_dir_o,
    output logic      busy_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic seen;
    logic lvl;
    int   k;
    task automatic half();
        repeat (4) begin
            @(posedge clk_i);
            if (done_i) seen = 1'b1;
        end
        lvl = ~lvl;
        shift_clk_o <= lvl;
    endtask : half
    ////////////////////////////////////////////////////////////////////
    initial begin
        // clock and enable idle low between steps; direction idles at the inverse of the last step's
        {shift_clk_o, step_en_o, step_dir_o, busy_o, lvl} = 5'h00;
        forever begin
            @(posedge clk_i);
            if (req_i) begin
                busy_o     <= 1'b1;
                seen       = 1'b0;
                half();
                // enable spans one shift period, rise to rise
                step_en_o  <= 1'b1;
                step_dir_o <= dir_i;
                half();
                half();
                // early: second request while busy, only on command
                step_en_o <= early_i;
                half();
                half();
                step_en_o  <= 1'b0;
                step_dir_o <= ~dir_i;
                // clock halts once done has come and gone
                for (k = 0; k < 60 && !(seen && !done_i && !lvl); k++) half();
                busy_o <= 1'b0;
            end
        end
    end
endmodule : fsps_step_model
`default_nettype wire

// file: fsps_top_tb.sv
`default_nettype none
module fsps_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_i = 1'b0, srst_i = 1'b1, src = 1'b0, src_run = 1'b1;
    logic        rng = 1'b0, hold = 1'b0, req = 1'b0, dir = 1'b0;
    logic        early = 1'b0, fb = 1'b1;
    logic [12:0] mul = 13'h0000, dv = 13'h0000;
    logic [1:0]  mode = 2'h0;
    logic [8:0]  ph = 9'h000;
    logic        sclk, sen, sdir, busy, done, fx, fxn, dsk, lk, cdone;
    logic [7:0]  st;
    int          fails = 0, samples_checked = 0, cyc = 0, sc = 0, dhi = 0;

    always #5 clk_i = ~clk_i;
    // source period 40 clk cycles, halts when src_run drops
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        sc  <= (sc == 39) ? 0 : sc + 1;
        src <= src_run & (sc < 20);
        dhi <= dhi + (done === 1'b1);
        if (cyc > 40000) begin
            fails++;
            report_and_stop();
        end
    end

    fsps_top DUT (.clk_i(clk_i), .srst_i(srst_i), .source_clk_in_i(src),
        .feedback_clk_in_used_i(fb), .synth_multiplier_i(mul),
        .synth_divisor_i(dv), .synth_freq_range_sel_i(rng),
        .shift_mode_sel_i(mode), .cfg_phase_shift_i(ph),
        .hold_config_until_lock_i(hold), .shift_clk_i(sclk),
        .shift_step_enable_i(sen), .shift_direction_i(sdir),
        .shift_step_done_o(done), .synth_clk_out_o(fx),
        .synth_clk_inv_out_o(fxn), .deskew_clk_out_o(dsk),
        .locked_o(lk), .config_done_o(cdone), .status_o(st));
    fsps_step_model partner (.clk_i(clk_i), .req_i(req), .dir_i(dir),
        .early_i(early), .done_i(done), .shift_clk_o(sclk),
        .step_en_o(sen), .step_dir_o(sdir), .busy_o(busy));

    ////////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        if (fails == 0 && samples_checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : report_and_stop
    task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check_val
    task automatic start(input logic [1:0] md, input logic [8:0] p,
                         input logic r, input logic h);
        @(posedge clk_i);
        {mode, ph, rng, hold, srst_i} <= {md, p, r, h, 1'b1};
        repeat (2) @(posedge clk_i);
        srst_i <= 1'b0;
        @(posedge clk_i);
        #1;
    endtask : start
    task automatic wait_lock(output int t);
        for (t = 0; t < 3000 && lk !== 1'b1; t++) @(posedge clk_i);
        check_val(t >= 256 && t < 3000, 1);
    endtask : wait_lock
    task automatic meas(input int n, output int ed, output int hi,
                        output int bad);
        logic p;
        ed = 0; hi = 0; bad = 0; p = fx;
        repeat (n) begin
            @(posedge clk_i);
            #1;
            ed += fx & !p; hi += fx; bad += (fxn !== ~fx); p = fx;
        end
    endtask : meas
    task automatic dly(output int d);
        logic p;
        @(posedge src);
        p = 1'b1; d = 0;
        while (d < 80 && !(dsk === 1'b1 && p === 1'b0)) begin
            p = dsk;
            @(posedge clk_i);
            #1;
            d++;
        end
    endtask : dly
    task automatic step(input logic up, input logic e);
        @(negedge clk_i) dhi = 0;
        @(posedge clk_i);
        {req, dir, early} <= {1'b1, up, e};
        @(posedge clk_i);
        req <= 1'b0;
        repeat (2) @(posedge clk_i);
        for (int k = 0; k < 600 && busy !== 1'b0; k++) @(posedge clk_i);
        repeat (3) @(posedge clk_i);
        #1;
        check_val(dhi, 8);
    endtask : step

    ////////////////////////////////////////////////////////////////////
    task automatic test_lock_defaults();
        int t0, t1, e, h, b;
        start(2'h0, 9'h000, 1'b0, 1'b1);
        check_val(cdone, 0);
        wait_lock(t0);
        @(posedge clk_i);
        #1;
        check_val(cdone, 1);
        meas(400, e, h, b);
        check_val(e, 40);
        check_val(h, 200);
        check_val(b, 0);
        start(2'h0, 9'h000, 1'b1, 1'b0);
        wait_lock(t1);
        check_val(t0 - t1 > 250 && t0 - t1 < 390, 1);
    endtask : test_lock_defaults
    task automatic test_mult_div();
        int t, e, h, b;
        {mul, dv} <= {13'h0003, 13'h0002};
        start(2'h0, 9'h000, 1'b0, 1'b0);
        @(posedge clk_i);
        mul <= 13'h0007;
        wait_lock(t);
        meas(800, e, h, b);
        check_val(e, 30);
        check_val(h, 400);
        check_val(b, 0);
        @(posedge clk_i);
        srst_i <= 1'b1;
        {mul, dv} <= {13'h0000, 13'h0000};
        @(posedge clk_i);
        #1;
        check_val({lk, fxn}, 1);
    endtask : test_mult_div
    task automatic test_fixed_shift();
        int         t, d0, d;
        logic [1:0] mds [4] = '{2'h1, 2'h1, 2'h1, 2'h0};
        logic [8:0] phs [4] = '{9'h000, 9'h080, 9'h1C0, 9'h080};
        int         exps [4] = '{0, 20, 30, 0};
        d0 = 0;
        for (int i = 0; i < 4; i++) begin
            start(mds[i], phs[i], 1'b0, 1'b0);
            wait_lock(t);
            dly(d);
            if (i == 0) d0 = d;
            check_val(d - d0, exps[i]);
        end
    endtask : test_fixed_shift
    task automatic test_steps();
        int t;
        start(2'h2, 9'h0FE, 1'b0, 1'b0);
        wait_lock(t);
        step(1'b1, 1'b1);
        check_val(st, 8'h00);
        step(1'b1, 1'b0);
        check_val(st, 8'h01);
        start(2'h2, 9'h0FE, 1'b0, 1'b0);
        wait_lock(t);
        step(1'b1, 1'b0);
        check_val(st, 8'h00);
        // down then up stays inside the range only if down decrements
        step(1'b0, 1'b0);
        step(1'b1, 1'b0);
        check_val(st, 8'h00);
    endtask : test_steps
    task automatic test_loss();
        int t;
        src_run <= 1'b0;
        for (t = 0; t < 4200 && st[1] !== 1'b1; t++) @(posedge clk_i);
        #1;
        check_val(t > 4000 && t < 4110, 1);
        check_val(lk, 0);
        @(posedge clk_i);
        fb <= 1'b0;
        repeat (2) @(posedge clk_i);
        #1;
        check_val(st[1], 0);
    endtask : test_loss

    initial begin
        test_lock_defaults();
        test_mult_div();
        test_fixed_shift();
        test_steps();
        test_loss();
        report_and_stop();
    end
endmodule : fsps_top_tb
`default_nettype wire
